// ==== inc/desync_cfg_map.svh ====
// register offsets, field positions, reset values and pacing constants
`ifndef DESYNC_CFG_MAP_SVH
`define DESYNC_CFG_MAP_SVH

// channel count and widths
`define NUM_CH          3
`define CTRL_W          8
`define PACE_W          16
`define LFSR_W          15
`define BUF_WIDTH       1
`define BUF_DEPTH       2

// register indices; byte address is four times the index
`define CTRL_IDX0       8'h06
`define CTRL_IDX1       8'h0e
`define CTRL_IDX2       8'h16
`define STATUS_IDX      8'h20

// channel control fields
`define CTRL_SR_BIT     0
`define CTRL_STS1_BIT   1
`define CTRL_E3_BIT     2
`define CTRL_LLB_BIT    3
`define CTRL_RLB_BIT    4
`define CTRL_PAT_BIT    5
`define CTRL_RW_MASK    8'h3f
`define CTRL_RESET      8'h00

// status fields
`define STAT_OVF_LSB    0
`define STAT_VLD_LSB    4
`define STAT_HOST_BIT   8

// line rates and system clock in kHz
`define SYS_CLK_KHZ     64'd125000
`define DS3_KHZ         64'd44736
`define E3_KHZ          64'd34368
`define STS1_KHZ        64'd51840
`define PACE_SCALE      64'd65536
`define PACE_DS3        (`DS3_KHZ * `PACE_SCALE / `SYS_CLK_KHZ)
`define PACE_E3         (`E3_KHZ * `PACE_SCALE / `SYS_CLK_KHZ)
`define PACE_STS1       (`STS1_KHZ * `PACE_SCALE / `SYS_CLK_KHZ)

// pattern generator seed, any non-zero value
`define LFSR_SEED       15'h0001
`define LFSR_TAP_A      14
`define LFSR_TAP_B      13

`endif

// ==== inc/desync_cfg_pkg.sv ====
// types shared by the channel configuration block
package desync_cfg_pkg;
`include "desync_cfg_map.svh"

  typedef logic [`NUM_CH-1:0] chan_vec_type;

  typedef struct packed {
    logic [`NUM_CH-1:0][`CTRL_W-1:0] ctrl;     // channel control registers
    chan_vec_type                    clk_s1;   // gapped clock, first sync stage
    chan_vec_type                    clk_s2;   // gapped clock, second sync stage
    chan_vec_type                    clk_s3;   // previous clock level for edges
    chan_vec_type                    dat_s1;   // data, first sync stage
    chan_vec_type                    dat_s2;   // data, second sync stage
    logic                            host_s1;  // host mode strap sync
    logic                            host_s2;
    chan_vec_type                    e3_s1;    // e3 strap sync
    chan_vec_type                    e3_s2;
    chan_vec_type                    sts_s1;   // sts-1 strap sync
    chan_vec_type                    sts_s2;
    logic                            sr_s1;    // single rail strap sync
    logic                            sr_s2;
    chan_vec_type                    cap_push; // captured bit ready
    chan_vec_type                    cap_bit;  // captured bit value
    logic [`NUM_CH-1:0][`PACE_W-1:0] acc;      // pacing phase accumulators
    logic [`NUM_CH-1:0][`LFSR_W-1:0] lfsr;     // pattern generators
    chan_vec_type                    line_data;
    chan_vec_type                    line_stb;
    chan_vec_type                    rate_e3;
    chan_vec_type                    rate_sts1;
    chan_vec_type                    single_rail;
    chan_vec_type                    rloop;
    chan_vec_type                    lloop;
    chan_vec_type                    pat;
    chan_vec_type                    ovf;      // sticky buffer overrun
    logic                            pready;
    logic                            pslverr;
    logic [31:0]                     prdata;
  } cfg_state_type;

endpackage

// ==== rtl/pair_buffer.sv ====
// small valid/ready buffer between bit capture and line pacing
`timescale 1ns/100ps
`include "desync_cfg_map.svh"
module pair_buffer #(
  parameter int WIDTH = `BUF_WIDTH,  // entry width
  parameter int DEPTH = `BUF_DEPTH   // number of entries
) (
  input  wire logic             clk_i,       // system clock
  input  wire logic             rst_n_i,     // synchronised reset, active low
  input  wire logic             in_valid_i,  // write side offers an entry
  input  wire logic [WIDTH-1:0] in_data_i,   // entry offered
  output      logic             in_ready_o,  // buffer has room
  output      logic             out_valid_o, // buffer holds an entry
  output      logic [WIDTH-1:0] out_data_o,  // oldest entry
  input  wire logic             out_ready_i  // drain side takes the entry
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // entries
    logic [PW-1:0]               wptr;  // next slot to fill
    logic [PW-1:0]               rptr;  // oldest slot
    logic [PW:0]                 count; // entries held
  } pair_state_type;

  pair_state_type st_q;
  pair_state_type st_d;
  logic           push;   // entry accepted this cycle
  logic           pop;    // entry drained this cycle

  assign in_ready_o  = (st_q.count != FULL);
  assign out_valid_o = (st_q.count != '0);
  assign out_data_o  = st_q.mem[st_q.rptr];

  // pointer and count update; push and pop in one cycle keep the count
  always_comb begin
    st_d = st_q;
    push = in_valid_i & in_ready_o;
    pop  = out_valid_o & out_ready_i;
    if (push) begin
      st_d.mem[st_q.wptr] = in_data_i;
      st_d.wptr = (st_q.wptr == LAST) ? '0 : st_q.wptr + PW'(1);
    end
    if (pop) begin
      st_d.rptr = (st_q.rptr == LAST) ? '0 : st_q.rptr + PW'(1);
    end
    st_d.count = st_q.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ==== rtl/desync_chan_cfg.sv ====
// per-channel transmit capture, rate and line format configuration with apb access
`timescale 1ns/100ps
`include "desync_cfg_map.svh"
module desync_chan_cfg
  import desync_cfg_pkg::*;
(
  input  wire logic               clk_sys_i,              // 125 mhz system clock
  input  wire logic               rstn_i,                 // async reset, active low
  input  wire logic               psel_i,                 // apb select
  input  wire logic               penable_i,              // apb access phase
  input  wire logic               pwrite_i,               // apb write
  input  wire logic [11:0]        paddr_i,                // apb byte address
  input  wire logic [31:0]        pwdata_i,               // apb write data
  input  wire logic [3:0]         pstrb_i,                // apb byte strobes
  output      logic [31:0]        prdata_o,               // apb read data
  output      logic               pready_o,               // apb ready
  output      logic               pslverr_o,              // apb error, unmapped
  input  wire logic               host_mode_i,            // high: registers rule
  input  wire logic [`NUM_CH-1:0] rate_sel_e3_i,          // e3 straps
  input  wire logic [`NUM_CH-1:0] rate_sel_sonet_or_t3_i, // sts-1 straps
  input  wire logic               single_dual_rail_sel_i, // single rail strap
  input  wire logic [`NUM_CH-1:0] tx_gapped_clock_in_i,   // mapper gapped clocks
  input  wire logic [`NUM_CH-1:0] tx_pos_data_in_i,       // mapper data lines
  input  wire logic [`NUM_CH-1:0] line_ready_i,           // line side accepts a bit
  output      logic [`NUM_CH-1:0] line_data_o,            // smoothed line bit
  output      logic [`NUM_CH-1:0] line_stb_o,             // line bit strobe
  output      logic [`NUM_CH-1:0] rate_sel_e3_o,          // channel runs e3
  output      logic [`NUM_CH-1:0] rate_sel_sonet_or_t3_o, // channel runs sts-1
  output      logic [`NUM_CH-1:0] single_dual_rail_sel_o, // channel single rail
  output      logic [`NUM_CH-1:0] remote_loop_en_o,       // remote loopback
  output      logic [`NUM_CH-1:0] local_loop_en_o,        // local loopback
  output      logic [`NUM_CH-1:0] pattern_gen_en_o        // pattern replaces data
);

  // pacing increments per rate, one carry per line bit
  localparam logic [`PACE_W-1:0] INC_DS3  = `PACE_W'(`PACE_DS3);
  localparam logic [`PACE_W-1:0] INC_E3   = `PACE_W'(`PACE_E3);
  localparam logic [`PACE_W-1:0] INC_STS1 = `PACE_W'(`PACE_STS1);

  logic [1:0]          rst_sync_q;     // reset release synchroniser
  logic                rst_n;          // synchronised reset, active low
  cfg_state_type       st_q;           // all block state
  cfg_state_type       st_d;           // next state
  chan_vec_type        pace;           // one-cycle line bit enables
  chan_vec_type        buf_in_ready;   // buffer has room
  chan_vec_type        buf_out_valid;  // buffer holds a bit
  chan_vec_type        buf_out_data;   // oldest buffered bit
  chan_vec_type        buf_out_ready;  // line side drains
  chan_vec_type        eff_e3;         // effective e3 choice
  chan_vec_type        eff_sts;        // effective sts-1 choice
  chan_vec_type        eff_sr;         // effective single rail
  chan_vec_type        eff_rlb;        // effective remote loop
  chan_vec_type        eff_llb;        // effective local loop
  chan_vec_type        eff_pat;        // effective pattern enable
  chan_vec_type        hit_ctrl;       // address hits a control register
  logic [`NUM_CH-1:0][`PACE_W:0] pace_sum; // accumulator plus increment
  logic [`NUM_CH-1:0][`PACE_W-1:0] pace_inc; // increment per channel
  logic [7:0]          reg_idx;        // word index of the access
  logic                hit_stat;       // address hits status
  logic                hit_any;        // mapped address
  logic                answer;         // access phase, answer next edge
  logic                commit;         // edge where the master sees pready
  logic [31:0]         rd_mux;         // read data before registering
  chan_vec_type        ovf_clr;        // software clears overrun bits

  // every assertion below, generate loop included, runs on the system clock
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  // release the reset through two flops so every flop leaves reset together
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // per-channel effective configuration, pacing and buffering
  for (genvar g = 0; g < `NUM_CH; g++) begin : g_ch
    // host mode reads the register, hardware mode reads the straps
    assign eff_e3[g]  = st_q.host_s2 ? st_q.ctrl[g][`CTRL_E3_BIT] : st_q.e3_s2[g];
    assign eff_sts[g] = st_q.host_s2 ? st_q.ctrl[g][`CTRL_STS1_BIT] : st_q.sts_s2[g];
    assign eff_sr[g]  = st_q.host_s2 ? st_q.ctrl[g][`CTRL_SR_BIT] : st_q.sr_s2;
    // loops and pattern have no straps, so hardware mode leaves them off
    assign eff_rlb[g] = st_q.host_s2 & st_q.ctrl[g][`CTRL_RLB_BIT];
    assign eff_llb[g] = st_q.host_s2 & st_q.ctrl[g][`CTRL_LLB_BIT];
    assign eff_pat[g] = st_q.host_s2 & st_q.ctrl[g][`CTRL_PAT_BIT];

    // phase accumulator stands in for the smoothing loop: bits leave at an even rate
    assign pace_inc[g] = st_q.rate_e3[g] ? INC_E3 :
                         (st_q.rate_sts1[g] ? INC_STS1 : INC_DS3);
    assign pace_sum[g] = {1'b0, st_q.acc[g]} + {1'b0, pace_inc[g]};
    assign pace[g]     = pace_sum[g][`PACE_W];

    // drain on a pace slot the line accepts; pattern mode discards buffered bits
    assign buf_out_ready[g] = pace[g] & line_ready_i[g];

    assign hit_ctrl[g] = (reg_idx == ((g == 0) ? `CTRL_IDX0 :
                                      ((g == 1) ? `CTRL_IDX1 : `CTRL_IDX2)));

    pair_buffer #(
      .WIDTH (`BUF_WIDTH),
      .DEPTH (`BUF_DEPTH)
    ) u_buf (
      .clk_i       (clk_sys_i),
      .rst_n_i     (rst_n),
      .in_valid_i  (st_q.cap_push[g]),
      .in_data_i   (st_q.cap_bit[g]),
      .in_ready_o  (buf_in_ready[g]),
      .out_valid_o (buf_out_valid[g]),
      .out_data_o  (buf_out_data[g]),
      .out_ready_i (buf_out_ready[g])
    );

    // a rise of the synchronised clock captures one bit, one cycle later
    capture_edge_a : assert property ($rose(st_q.clk_s2[g]) |=>
      st_q.cap_push[g] && st_q.cap_bit[g] == $past(st_q.dat_s2[g]))
      else $error("gapped clock edge did not capture its bit");
    single_push_a : assert property (st_q.cap_push[g] |=> !st_q.cap_push[g])
      else $error("one clock edge captured twice");
    ds3_host_a : assert property (st_q.host_s2 && st_q.ctrl[g][2:1] == 2'b00 |=>
      !rate_sel_e3_o[g] && !rate_sel_sonet_or_t3_o[g])
      else $error("host mode ds3 selection not applied");
    ds3_strap_a : assert property (!st_q.host_s2 && !st_q.e3_s2[g] && !st_q.sts_s2[g] |=>
      !rate_sel_e3_o[g] && !rate_sel_sonet_or_t3_o[g])
      else $error("strap ds3 selection not applied");
    rail_host_a : assert property (st_q.host_s2 |=>
      single_dual_rail_sel_o[g] == $past(st_q.ctrl[g][`CTRL_SR_BIT]))
      else $error("host single rail bit not applied");
    rail_strap_a : assert property (!st_q.host_s2 && st_q.sr_s2 |=> single_dual_rail_sel_o[g])
      else $error("single rail strap not applied");
    unused_bits_a : assert property (st_q.ctrl[g][7:6] == 2'b00)
      else $error("read-only control bits changed");
    loop_field_a : assert property (st_q.host_s2 && st_q.ctrl[g][`CTRL_RLB_BIT] |=>
      remote_loop_en_o[g])
      else $error("remote loopback bit not applied");
    e3_wins_a : assert property (rate_sel_e3_o[g] |-> !rate_sel_sonet_or_t3_o[g])
      else $error("e3 and sts-1 selected together");

    // a paced pop of a buffered bit reaches the line pins on the next edge
    sequence pop_seq;
      pace[g] && line_ready_i[g] && buf_out_valid[g] && !st_q.pat[g];
    endsequence
    line_out_a : assert property (pop_seq |=>
      line_stb_o[g] && line_data_o[g] == $past(buf_out_data[g]))
      else $error("buffered bit not sent to line");
    stall_hold_a : assert property (!line_ready_i[g] |=> !line_stb_o[g])
      else $error("line strobe during receiver stall");
  end

  // apb decode; upper address bits must be zero for a hit
  assign reg_idx  = paddr_i[9:2];
  assign hit_stat = (reg_idx == `STATUS_IDX);
  assign hit_any  = (paddr_i[11:10] == 2'b00) & (hit_stat | (|hit_ctrl));
  assign answer   = psel_i & penable_i & ~st_q.pready;
  assign commit   = psel_i & penable_i & st_q.pready & hit_any;
  assign ovf_clr  = (commit & pwrite_i & hit_stat & pstrb_i[0]) ?
                    pwdata_i[`STAT_OVF_LSB +: `NUM_CH] : '0;

  // read mux; reserved bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int c = 0; c < `NUM_CH; c++) begin
      if (hit_ctrl[c]) begin
        rd_mux[`CTRL_W-1:0] = st_q.ctrl[c];
      end
    end
    if (hit_stat) begin
      rd_mux[`STAT_OVF_LSB +: `NUM_CH] = st_q.ovf;
      rd_mux[`STAT_VLD_LSB +: `NUM_CH] = buf_out_valid;
      rd_mux[`STAT_HOST_BIT]           = st_q.host_s2;
    end
    if (paddr_i[11:10] != 2'b00) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // next state for the whole block
  always_comb begin
    st_d = st_q;
    // two-flop synchronisers for pins from outside the clock domain
    st_d.clk_s1  = tx_gapped_clock_in_i;
    st_d.clk_s2  = st_q.clk_s1;
    st_d.clk_s3  = st_q.clk_s2;
    st_d.dat_s1  = tx_pos_data_in_i;
    st_d.dat_s2  = st_q.dat_s1;
    st_d.host_s1 = host_mode_i;
    st_d.host_s2 = st_q.host_s1;
    st_d.e3_s1   = rate_sel_e3_i;
    st_d.e3_s2   = st_q.e3_s1;
    st_d.sts_s1  = rate_sel_sonet_or_t3_i;
    st_d.sts_s2  = st_q.sts_s1;
    st_d.sr_s1   = single_dual_rail_sel_i;
    st_d.sr_s2   = st_q.sr_s1;
    // data travel beside the clock, so a rise sees the bit the mapper set up
    st_d.cap_push = st_q.clk_s2 & ~st_q.clk_s3;
    st_d.cap_bit  = st_q.dat_s2;
    // registered configuration outputs
    st_d.rate_e3     = eff_e3;
    st_d.rate_sts1   = eff_sts & ~eff_e3;
    st_d.single_rail = eff_sr;
    st_d.rloop       = eff_rlb;
    st_d.lloop       = eff_llb;
    st_d.pat         = eff_pat;
    // overrun: the mapper cannot be stalled, so a full buffer drops the bit
    st_d.ovf = (st_q.ovf & ~ovf_clr) | (st_q.cap_push & ~buf_in_ready);
    for (int c = 0; c < `NUM_CH; c++) begin
      st_d.acc[c] = pace_sum[c][`PACE_W-1:0];
      st_d.line_stb[c] = pace[c] & line_ready_i[c] &
                         (st_q.pat[c] | buf_out_valid[c]);
      if (st_d.line_stb[c]) begin
        // pattern bits come from the generator, others from the buffer
        if (st_q.pat[c]) begin
          st_d.line_data[c] = st_q.lfsr[c][`LFSR_W-1];
          st_d.lfsr[c] = {st_q.lfsr[c][`LFSR_W-2:0],
                          st_q.lfsr[c][`LFSR_TAP_A] ^ st_q.lfsr[c][`LFSR_TAP_B]};
        end else begin
          st_d.line_data[c] = buf_out_data[c];
        end
      end
      // write takes effect at the edge where the master sees pready
      if (commit && pwrite_i && hit_ctrl[c] && pstrb_i[0]) begin
        st_d.ctrl[c] = pwdata_i[`CTRL_W-1:0] & `CTRL_RW_MASK;
      end
    end
    // apb answer: one wait state, data and error registered with ready
    st_d.pready  = answer;
    st_d.pslverr = answer & ~hit_any;
    if (answer) begin
      st_d.prdata = pwrite_i ? 32'h0000_0000 : rd_mux;
    end
  end

  // state register; pattern generators leave reset seeded
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.ctrl <= {`NUM_CH{`CTRL_RESET}};
      st_q.lfsr <= {`NUM_CH{`LFSR_SEED}};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign prdata_o               = st_q.prdata;
  assign pready_o               = st_q.pready;
  assign pslverr_o              = st_q.pslverr;
  assign line_data_o            = st_q.line_data;
  assign line_stb_o             = st_q.line_stb;
  assign rate_sel_e3_o          = st_q.rate_e3;
  assign rate_sel_sonet_or_t3_o = st_q.rate_sts1;
  assign single_dual_rail_sel_o = st_q.single_rail;
  assign remote_loop_en_o       = st_q.rloop;
  assign local_loop_en_o        = st_q.lloop;
  assign pattern_gen_en_o       = st_q.pat;

  // apb answer stands one cycle after the access phase starts
  sequence access_seq;
    psel_i && penable_i && !pready_o;
  endsequence
  apb_answer_a : assert property (access_seq |=> pready_o ##1 !pready_o)
    else $error("apb answer not a single cycle");
  apb_error_a : assert property (pslverr_o |-> pready_o)
    else $error("apb error without ready");
endmodule

// ==== verification/gapped_mapper_model.sv ====
// behavioural mapper that drives one gapped clock and one data line into a channel
`timescale 1ns/100ps
module gapped_mapper_model (
  output logic tx_clk_o,  // gapped clock, idles low between payload bits
  output logic tx_data_o  // whole stream, overhead bits included
);
  initial begin
    tx_clk_o  = 1'h0;
    tx_data_o = 1'h0;
  end
  // one 80 ns slot per stream bit; the rise sits 20 ns into the slot so data is settled around it
  task automatic send(input logic [15:0] bits, input logic [15:0] payload);
    #2;                            // step off the system clock edges
    for (int i = 0; i < 16; i++) begin
      tx_data_o = bits[i];         // data line feeds the positive data input
      #20;
      if (payload[i]) begin
        tx_clk_o = 1'h1;           // clock pulses only while a payload bit is present
      end
      #40;
      tx_clk_o = 1'h0;             // overhead slots keep the clock gapped
      #20;
    end
    // after the burst the line stops showing the last bit
    tx_data_o = ~tx_data_o;
  endtask
endmodule

// ==== verification/test_desync_chan_cfg.sv ====
// self-checking bench: apb register access, strap mode and gapped-clock data path
`timescale 1ns/100ps
`include "desync_cfg_map.svh"
module test_desync_chan_cfg;
  logic        clk_sys    = 1'h0;  // 125 mhz system clock
  logic        rstn       = 1'h0;  // reset, active low
  logic        psel       = 1'h0;  // apb master signals
  logic        penable    = 1'h0;
  logic        pwrite     = 1'h0;
  logic [11:0] paddr      = 12'h0;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  pstrb      = 4'hf;
  logic        host_mode  = 1'h1;  // registers rule at start
  logic [2:0]  e3_strap   = 3'h0;  // strap levels
  logic [2:0]  sts_strap  = 3'h0;
  logic        sr_strap   = 1'h0;
  logic [2:0]  line_ready = 3'h7;  // line side acceptance
  wire  [2:0]  map_clk, map_data, line_data, line_stb;
  wire  [2:0]  o_e3, o_sts, o_sr, o_rl, o_ll, o_pat;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  int          fails = 0, num_checks = 0, cycles = 0;
  logic        collect = 1'h0;     // gather channel 0 line bits
  logic        got[$];             // line bits seen
  desync_chan_cfg dut (.clk_sys_i(clk_sys), .rstn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .host_mode_i(host_mode), .rate_sel_e3_i(e3_strap), .rate_sel_sonet_or_t3_i(sts_strap),
    .single_dual_rail_sel_i(sr_strap), .tx_gapped_clock_in_i(map_clk),
    .tx_pos_data_in_i(map_data), .line_ready_i(line_ready), .line_data_o(line_data),
    .line_stb_o(line_stb), .rate_sel_e3_o(o_e3), .rate_sel_sonet_or_t3_o(o_sts),
    .single_dual_rail_sel_o(o_sr), .remote_loop_en_o(o_rl), .local_loop_en_o(o_ll),
    .pattern_gen_en_o(o_pat));
  // one mapper per channel, only channel 0 carries traffic
  for (genvar g = 0; g < 3; g++) begin : gen_map
    gapped_mapper_model u_map (.tx_clk_o(map_clk[g]), .tx_data_o(map_data[g]));
  end
  always #4 clk_sys = ~clk_sys;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (collect && line_stb[0] === 1'h1) got.push_back(line_data[0]);
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1);
    chk("apb wait", n, 32'h2);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [11:0] ctrl_addr(input int c);
    return 12'(4 * (c == 0 ? `CTRL_IDX0 : (c == 1 ? `CTRL_IDX1 : `CTRL_IDX2)));
  endfunction
  task automatic reset_values();
    logic [31:0] rd;
    logic        err;
    for (int c = 0; c < 3; c++) begin
      apb(1'h0, ctrl_addr(c), 32'h0, rd, err);
      chk("ctrl reset", rd, 32'h0);
    end
    chk("cfg outputs reset", {o_e3, o_sts, o_sr, o_rl, o_ll, o_pat}, 32'h0);
    $display("reset value test done");
  endtask
  // write a control value, read it back and watch the per-channel levels
  task automatic host_cfg(input int c, input logic [7:0] v);
    logic [31:0] rd;
    logic        err;
    apb(1'h1, ctrl_addr(c), {24'h0, v}, rd, err);
    apb(1'h0, ctrl_addr(c), 32'h0, rd, err);
    chk("ctrl readback", rd, {24'h0, v & `CTRL_RW_MASK});
    chk("e3 out", o_e3[c], v[2]);
    chk("sts out", o_sts[c], v[1] & ~v[2]);
    chk("rail out", o_sr[c], v[0]);
    chk("loops pattern", {o_pat[c], o_rl[c], o_ll[c]}, v[5:3]);
    $display("host config test done ch %0d value %h", c, v);
  endtask
  task automatic unmapped();
    logic [31:0] rd;
    logic        err;
    apb(1'h1, 12'h040, 32'hff, rd, err);
    chk("unmapped write err", err, 1'h1);
    apb(1'h0, 12'h040, 32'h0, rd, err);
    chk("unmapped read err", err, 32'h1);
    chk("unmapped read data", rd, 32'h0);
    $display("unmapped address test done");
  endtask
  // strap levels take effect three edges after they change
  task automatic hw_straps(input logic [2:0] e3, input logic [2:0] sts, input logic sr);
    host_mode <= 1'h0;
    e3_strap  <= e3;
    sts_strap <= sts;
    sr_strap  <= sr;
    repeat (5) @(posedge clk_sys);
    chk("hw e3", o_e3, e3);
    chk("hw sts", o_sts, sts & ~e3);
    chk("hw rail", o_sr, {3{sr}});
    chk("hw loops", {o_pat, o_rl, o_ll}, 32'h0);
    $display("strap test done");
  endtask
  // gapped burst with the line stalled at first; no bit may be lost or reordered
  task automatic data_path();
    logic [15:0] bits;
    logic [15:0] mask;
    logic        exp[$];
    logic [31:0] rd;
    logic        err;
    bits = 16'h5a3c;
    mask = 16'hef7d;
    for (int i = 0; i < 16; i++) if (mask[i]) exp.push_back(bits[i]);
    host_cfg(0, 8'h01); // one-line mapper needs single rail
    got.delete();
    collect = 1'h1;
    line_ready <= 3'h0;
    fork
      gen_map[0].u_map.send(bits, mask);
      begin
        repeat (26) @(posedge clk_sys);
        line_ready <= 3'h7;
      end
    join
    repeat (40) @(posedge clk_sys);
    collect = 1'h0;
    chk("line bit count", got.size(), exp.size());
    foreach (exp[i]) chk("line bit", got[i], exp[i]);
    apb(1'h0, 12'h080, 32'h0, rd, err);
    chk("status clean", rd[6:0], 7'h0);
    $display("data path test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    reset_values();
    host_cfg(0, 8'hff);
    host_cfg(1, 8'h02);
    host_cfg(2, 8'h01);
    host_cfg(0, 8'h00);
    unmapped();
    hw_straps(3'h2, 3'h3, 1'h1);
    hw_straps(3'h0, 3'h0, 1'h1);
    hw_straps(3'h5, 3'h7, 1'h0);
    host_mode <= 1'h1;
    repeat (4) @(posedge clk_sys);
    data_path();
    tally_and_finish();
  end
endmodule
